// file: design/ilc_defines.svh
`ifndef ILC_DEFINES_SVH
`define ILC_DEFINES_SVH

// Register bus geometry
`define ILC_ADDR_W 8
`define ILC_DATA_W 32
`define ILC_LINES 32

// Register byte offsets
`define ILC_OFS_OWN_SET 8'h00
`define ILC_OFS_OWN_CLR 8'h04
`define ILC_OFS_OWN_STS 8'h08
`define ILC_OFS_DRV_SET 8'h10
`define ILC_OFS_DRV_CLR 8'h14
`define ILC_OFS_DRV_STS 8'h18
`define ILC_OFS_FLT_SET 8'h20
`define ILC_OFS_FLT_CLR 8'h24
`define ILC_OFS_FLT_STS 8'h28
`define ILC_OFS_OUT_SET 8'h30
`define ILC_OFS_OUT_CLR 8'h34
`define ILC_OFS_OUT_STS 8'h38
`define ILC_OFS_PIN_LVL 8'h3c
`define ILC_OFS_IRQ_EN 8'h40
`define ILC_OFS_IRQ_DIS 8'h44
`define ILC_OFS_IRQ_MSK 8'h48
`define ILC_OFS_IRQ_PND 8'h4c
`define ILC_OFS_OD_SET 8'h50
`define ILC_OFS_OD_CLR 8'h54
`define ILC_OFS_OD_STS 8'h58
`define ILC_OFS_PU_OFF 8'h60
`define ILC_OFS_PU_ON 8'h64
`define ILC_OFS_PU_STS 8'h68
`define ILC_OFS_FN_A 8'h70
`define ILC_OFS_FN_B 8'h74
`define ILC_OFS_FN_STS 8'h78
`define ILC_OFS_WM_SET 8'ha0
`define ILC_OFS_WM_CLR 8'ha4
`define ILC_OFS_WM_STS 8'ha8

// Reset values
`define ILC_RST_ZERO 32'h00000000
`define ILC_RST_OWN 32'h00000000
`define ILC_ALL_LINES 32'hffffffff

// Filter latency in master clock cycles when the filter is on
`define ILC_FLT_DELAY_NS 10
`define ILC_CLK_PERIOD_NS 10
`define ILC_FLT_DELAY_CYC (`ILC_FLT_DELAY_NS / `ILC_CLK_PERIOD_NS)

`endif

// file: design/ilc_pkg.sv
package ilc_pkg;

   // Level and drive enable of a group of lines, bit n for line n
   typedef struct packed {
      logic [31:0] level;
      logic [31:0] enable;
   } ilc_drive_t;

endpackage : ilc_pkg

// file: design/ilc_in_cond.sv
`timescale 1ns/10ps
`default_nettype none

module ilc_in_cond #(
   parameter int WIDTH = 32
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pclk_en,
   input wire logic [WIDTH-1:0] i_raw,
   input wire logic [WIDTH-1:0] i_flt_on,
   output logic [WIDTH-1:0] o_level
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] dly_ff;

   // Two-flop synchroniser, frozen while the controller clock is off
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else if (i_pclk_en) begin
         meta_ff <= i_raw;
         sync_ff <= meta_ff;
      end
   end

   // Filter stage: one extra cycle of delay only, so a glitch caught by the synchroniser still reaches it
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         dly_ff <= '0;
      end else if (i_pclk_en) begin
         dly_ff <= sync_ff;
      end
   end

   // Per line choice of filtered or plain level
   assign o_level = (i_flt_on & dly_ff) | (~i_flt_on & sync_ff);

endmodule : ilc_in_cond

`default_nettype wire

// file: design/ilc_top.sv
// Overview of operation
// - With filter on, full-cycle pulses pass, and so does any glitch the synchroniser samples.
// - Pulses between half and one cycle may pass or be rejected.
// - Filter adds one cycle of latency on a change before a rising edge.
// - Filter enable and disable writes set and clear filter status bits.
// - Filter touches only pin level readback and change detection, not peripherals.
// - Filtering happens only while the controller clock is enabled.
// - Interrupt enable and disable writes set and clear the mask bits.
// - Changes are found by comparing two successive samples, clock enabled.
// - Change detection works on every line whatever its configuration.
// - A change sets its pending bit; with mask set the interrupt rises.
// - All line requests are ORed into one interrupt output.
// - Reading the pending register clears every pending bit at once.
// - Every register is 32 bits, bit n serves line n.
// - Unimplemented line bits ignore writes and read as zero.
// - Lines without a peripheral always read owned, ignoring ownership writes.
// - Ownership reset value is a product parameter.
// - Output data is directly writable only where the write mask allows.
// - Pin level register shows actual line levels after reset.
// - Pending register resets to zero but may soon catch changes.
// - Function A write clears select bit, function B write sets it.
// - Ownership set write gives the pin to the controller.
// - Ownership clear write hands the pin to its selected peripheral.
// - Owned-zero lines follow peripheral A or B; owned-one lines follow controller.
// - Set and clear output writes change the driven data bits.
// - Direct output writes change only bits whose mask bit is set.
// - Pull-up status one means the pull-up is off.
`timescale 1ns/10ps
`default_nettype none

`include "ilc_defines.svh"

module ilc_top
   import ilc_pkg::*;
#(
   parameter logic [31:0] LINE_MASK = `ILC_ALL_LINES,
   parameter logic [31:0] MUX_MASK = `ILC_ALL_LINES,
   parameter logic [31:0] OWN_RESET = `ILC_RST_OWN
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pclk_en,
   input wire logic [`ILC_ADDR_W-1:0] i_addr,
   input wire logic [`ILC_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [`ILC_DATA_W-1:0] o_rdata,
   input wire logic [31:0] i_pin_in,
   output ilc_drive_t o_pin,
   output logic [31:0] o_pullup_en,
   input wire ilc_drive_t i_per_a,
   input wire ilc_drive_t i_per_b,
   output logic [31:0] o_per_in,
   output logic o_irq
);

   // Configuration state, one flop per line and register
   logic [31:0] own_ff;
   logic [31:0] drv_ff;
   logic [31:0] flt_ff;
   logic [31:0] out_ff;
   logic [31:0] msk_ff;
   logic [31:0] pnd_ff;
   logic [31:0] od_ff;
   logic [31:0] pu_ff;
   logic [31:0] fn_ff;
   logic [31:0] wm_ff;
   logic [31:0] prev_ff;
   logic [31:0] rdata_ff;
   ilc_drive_t pin_ff;

   logic [31:0] nxt_own;
   logic [31:0] nxt_drv;
   logic [31:0] nxt_flt;
   logic [31:0] nxt_out;
   logic [31:0] nxt_msk;
   logic [31:0] nxt_pnd;
   logic [31:0] nxt_od;
   logic [31:0] nxt_pu;
   logic [31:0] nxt_fn;
   logic [31:0] nxt_wm;
   logic [31:0] nxt_rdata;
   ilc_drive_t nxt_pin;

   logic [31:0] wd;
   logic [31:0] level;
   logic [31:0] change;
   logic pnd_rd;

   // Write data limited to implemented lines
   assign wd = i_wdata & LINE_MASK;

   // Write strobes per offset
   function automatic logic hit(input logic [`ILC_ADDR_W-1:0] ofs);
      hit = i_wr && (i_addr == ofs);
   endfunction : hit

   // Set and clear pair helper
   function automatic logic [31:0] setclr(
      input logic [31:0] cur,
      input logic [`ILC_ADDR_W-1:0] set_ofs,
      input logic [`ILC_ADDR_W-1:0] clr_ofs
   );
      logic [31:0] v;
      v = cur;
      if (hit(set_ofs)) begin
         v = v | wd;
      end
      if (hit(clr_ofs)) begin
         v = v & ~wd;
      end
      setclr = v;
   endfunction : setclr

   // Input synchroniser and glitch filter, used only for readback and change detection
   ilc_in_cond #(
      .WIDTH(32)
   ) u_in_cond (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_pclk_en(i_pclk_en),
      .i_raw(i_pin_in),
      .i_flt_on(flt_ff),
      .o_level(level)
   );

   // Peripherals always see the raw pin, never the filtered level
   assign o_per_in = i_pin_in;

   // Next ownership: set gives the line to the controller, clear to the peripheral
   always_comb begin
      nxt_own = setclr(own_ff, `ILC_OFS_OWN_SET, `ILC_OFS_OWN_CLR);
   end

   // Ownership register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         own_ff <= OWN_RESET;
      end else begin
         own_ff <= nxt_own;
      end
   end

   // Next drive enable
   always_comb begin
      nxt_drv = setclr(drv_ff, `ILC_OFS_DRV_SET, `ILC_OFS_DRV_CLR);
   end

   // Drive enable register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         drv_ff <= `ILC_RST_ZERO;
      end else begin
         drv_ff <= nxt_drv;
      end
   end

   // Next filter status
   always_comb begin
      nxt_flt = setclr(flt_ff, `ILC_OFS_FLT_SET, `ILC_OFS_FLT_CLR);
   end

   // Filter status register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         flt_ff <= `ILC_RST_ZERO;
      end else begin
         flt_ff <= nxt_flt;
      end
   end

   // Next output data: set/clear writes, plus masked direct writes
   always_comb begin
      nxt_out = setclr(out_ff, `ILC_OFS_OUT_SET, `ILC_OFS_OUT_CLR);
      if (hit(`ILC_OFS_OUT_STS)) begin
         nxt_out = (out_ff & ~wm_ff) | (wd & wm_ff);
      end
   end

   // Output data register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         out_ff <= `ILC_RST_ZERO;
      end else begin
         out_ff <= nxt_out;
      end
   end

   // Next interrupt mask
   always_comb begin
      nxt_msk = setclr(msk_ff, `ILC_OFS_IRQ_EN, `ILC_OFS_IRQ_DIS);
   end

   // Interrupt mask register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         msk_ff <= `ILC_RST_ZERO;
      end else begin
         msk_ff <= nxt_msk;
      end
   end

   // Next open drain status
   always_comb begin
      nxt_od = setclr(od_ff, `ILC_OFS_OD_SET, `ILC_OFS_OD_CLR);
   end

   // Open drain register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         od_ff <= `ILC_RST_ZERO;
      end else begin
         od_ff <= nxt_od;
      end
   end

   // Next pull-up status: the off write sets, the on write clears
   always_comb begin
      nxt_pu = setclr(pu_ff, `ILC_OFS_PU_OFF, `ILC_OFS_PU_ON);
   end

   // Pull-up register; a set bit means the pull-up is off
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pu_ff <= `ILC_RST_ZERO;
      end else begin
         pu_ff <= nxt_pu;
      end
   end

   // Pull-up controls toward the pads
   assign o_pullup_en = ~pu_ff & LINE_MASK;

   // Next function select: B write sets, A write clears
   always_comb begin
      nxt_fn = setclr(fn_ff, `ILC_OFS_FN_B, `ILC_OFS_FN_A);
   end

   // Function select register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fn_ff <= `ILC_RST_ZERO;
      end else begin
         fn_ff <= nxt_fn;
      end
   end

   // Next direct write mask
   always_comb begin
      nxt_wm = setclr(wm_ff, `ILC_OFS_WM_SET, `ILC_OFS_WM_CLR);
   end

   // Direct write mask register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wm_ff <= `ILC_RST_ZERO;
      end else begin
         wm_ff <= nxt_wm;
      end
   end

   // Change detection compares successive conditioned samples of every line
   assign change = i_pclk_en ? ((level ^ prev_ff) & LINE_MASK) : '0;

   // Previous sample, held while the controller clock is off
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         prev_ff <= `ILC_RST_ZERO;
      end else if (i_pclk_en) begin
         prev_ff <= level;
      end
   end

   // Pending read clears everything; a change in the same cycle still lands
   assign pnd_rd = i_rd && (i_addr == `ILC_OFS_IRQ_PND);

   always_comb begin
      nxt_pnd = pnd_rd ? '0 : pnd_ff;
      nxt_pnd = nxt_pnd | change;
   end

   // Pending register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pnd_ff <= `ILC_RST_ZERO;
      end else begin
         pnd_ff <= nxt_pnd;
      end
   end

   // Single interrupt: OR of every pending and unmasked line
   assign o_irq = |(pnd_ff & msk_ff);

   // Pad drive: controller or selected peripheral, open drain only pulls low
   always_comb begin
      logic [31:0] lvl;
      logic [31:0] en;
      logic [31:0] ctl;
      ctl = own_ff | ~MUX_MASK;
      lvl = (ctl & out_ff)
         | (~ctl & fn_ff & i_per_b.level)
         | (~ctl & ~fn_ff & i_per_a.level);
      en = (ctl & drv_ff)
         | (~ctl & fn_ff & i_per_b.enable)
         | (~ctl & ~fn_ff & i_per_a.enable);
      nxt_pin.enable = (en & ~(od_ff & lvl)) & LINE_MASK;
      nxt_pin.level = lvl & ~od_ff & LINE_MASK;
   end

   // Registered pad drive
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pin_ff <= '0;
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   assign o_pin = pin_ff;

   // Read multiplexer; write-only and reserved offsets read zero
   always_comb begin
      nxt_rdata = '0;
      if (i_rd) begin
         case (i_addr)
            `ILC_OFS_OWN_STS: begin
               nxt_rdata = own_ff | ~MUX_MASK;
            end
            `ILC_OFS_DRV_STS: begin
               nxt_rdata = drv_ff;
            end
            `ILC_OFS_FLT_STS: begin
               nxt_rdata = flt_ff;
            end
            `ILC_OFS_OUT_STS: begin
               nxt_rdata = out_ff;
            end
            `ILC_OFS_PIN_LVL: begin
               nxt_rdata = level;
            end
            `ILC_OFS_IRQ_MSK: begin
               nxt_rdata = msk_ff;
            end
            `ILC_OFS_IRQ_PND: begin
               nxt_rdata = pnd_ff;
            end
            `ILC_OFS_OD_STS: begin
               nxt_rdata = od_ff;
            end
            `ILC_OFS_PU_STS: begin
               nxt_rdata = pu_ff;
            end
            `ILC_OFS_FN_STS: begin
               nxt_rdata = fn_ff;
            end
            `ILC_OFS_WM_STS: begin
               nxt_rdata = wm_ff;
            end
            default: begin
               nxt_rdata = '0;
            end
         endcase
         nxt_rdata = nxt_rdata & LINE_MASK;
      end
   end

   // Read data stands for one cycle after the strobe
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign o_rdata = rdata_ff;

endmodule : ilc_top

`default_nettype wire

// file: verification/ilc_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module ilc_pad_model
   import ilc_pkg::*;
(
   input wire logic i_clk,
   input wire ilc_drive_t i_drv,
   input wire logic [31:0] i_pu,
   input wire logic [31:0] i_ext,
   output logic [31:0] o_pin,
   output ilc_drive_t o_per_a,
   output ilc_drive_t o_per_b
);
   logic [31:0] cnt_ff = 32'h1;

   // Pad wire: our driver wins, else pull-up, else the outside level
   assign o_pin = (i_drv.enable & i_drv.level) | (~i_drv.enable & (i_pu | i_ext));

   // Peripherals change what they drive on every cycle
   always_ff @(posedge i_clk) begin
      cnt_ff <= cnt_ff * 32'h0019660d + 32'h3c6ef35f;
   end

   assign o_per_a = {cnt_ff, ~cnt_ff};
   assign o_per_b = {cnt_ff ^ 32'h5a5a5a5a, cnt_ff};
endmodule : ilc_pad_model

`default_nettype wire

// file: verification/ilc_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "ilc_defines.svh"

module ilc_top_asserts (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pclk_en,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [31:0] i_pin_in,
   input wire logic [31:0] o_pullup_en,
   input wire logic [31:0] o_per_in,
   input wire logic o_irq
);
   logic [3:0] quiet_ff;
   wire rd_pnd = i_rd && i_addr == `ILC_OFS_IRQ_PND;

   // Cycles since the pads last moved with the clock running
   always_ff @(posedge i_clk) begin
      if (i_srst || !i_pclk_en || !$stable(i_pin_in)) quiet_ff <= '0;
      else if (quiet_ff != 4'hf) quiet_ff <= quiet_ff + 4'h1;
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_rdata_idle:
      assert property (!i_rd |=> o_rdata == '0) else $error("read data without a read");
   a_wo_read:
      assert property (i_rd && i_addr inside {8'h00, 8'h0c, 8'h9c} |=> o_rdata == '0)
         else $error("write-only or reserved read not zero");
   a_per_pass:
      assert property (o_per_in == i_pin_in) else $error("peripheral input differs from pad");
   a_pullup_off:
      assert property (i_wr && i_addr == `ILC_OFS_PU_OFF |=> (o_pullup_en & $past(i_wdata)) == '0)
         else $error("pull-up still on");
   a_irq_off:
      assert property (i_wr && i_addr == `ILC_OFS_IRQ_DIS && i_wdata == '1 |=> !o_irq)
         else $error("irq with all masks off");
   a_irq_cause:
      assert property (o_irq && rd_pnd |=> o_rdata != '0) else $error("irq with nothing pending");
   a_pnd_clear:
      assert property (rd_pnd && quiet_ff > 4'h6 |=> !o_irq) else $error("irq after pending read");
   a_irq_hold:
      assert property (o_irq && !rd_pnd && !(i_wr && i_addr == `ILC_OFS_IRQ_DIS) |=> o_irq)
         else $error("irq dropped on its own");
   a_irq_frozen:
      assert property (!i_pclk_en [*3] ##0 (!o_irq && !i_wr) |=> !o_irq)
         else $error("irq while clock stopped");

   cover property (rd_pnd && o_irq);
   cover property (!i_pclk_en ##1 i_pclk_en);
   cover property (i_wr && i_addr == `ILC_OFS_OUT_STS);
endmodule : ilc_top_asserts

`default_nettype wire

// file: verification/tb_io_line_controller.sv
`timescale 1ns/10ps
`default_nettype none
`include "ilc_defines.svh"

module tb_io_line_controller
   import ilc_pkg::*;
;
   localparam logic [31:0] LM = 32'h7fffffff;
   localparam logic [31:0] MM = 32'hfffffff0;
   localparam logic [31:0] OWN_RST = 32'h000000f0;
   logic i_clk = 0;
   logic i_srst = 1;
   logic i_pclk_en = 1;
   logic i_wr = 0;
   logic i_rd = 0;
   logic o_irq;
   logic [7:0] i_addr = '0;
   logic [31:0] i_wdata = '0, o_rdata, i_pin_in, o_pullup_en, o_per_in, ext = '0, d;
   logic [31:0] sh [9];
   logic [7:0] so [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h74, 8'ha0};
   logic [7:0] ca [7] = '{8'h00, 8'h14, 8'h60, 8'h24, 8'h44, 8'h34, 8'h54};
   ilc_drive_t o_pin, i_per_a, i_per_b, pd;
   integer seed = 32'h60d8;
   int n_fail = 0;
   int total_checks = 0;
   int k, op, n0, n1;

   // Clock
   initial forever #5 i_clk = ~i_clk;

   ilc_top #(.LINE_MASK(LM), .MUX_MASK(MM), .OWN_RESET(OWN_RST)) DUT (.i_clk(i_clk),
      .i_srst(i_srst), .i_pclk_en(i_pclk_en), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(i_pin_in), .o_pin(o_pin),
      .o_pullup_en(o_pullup_en), .i_per_a(i_per_a), .i_per_b(i_per_b),
      .o_per_in(o_per_in), .o_irq(o_irq));

   ilc_pad_model pads (.i_clk(i_clk), .i_drv(o_pin), .i_pu(o_pullup_en), .i_ext(ext),
      .o_pin(i_pin_in), .o_per_a(i_per_a), .o_per_b(i_per_b));

   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 0;
   endtask : wr

   task automatic rdc(string s, logic [7:0] a, logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 0;
      #1 chk(s, e, o_rdata);
   endtask : rdc

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test

   // Offset of the set, clear or status register of triple k
   function automatic logic [7:0] off(int k, int op);
      if (k == 7) return op == 0 ? 8'h74 : op == 1 ? 8'h70 : 8'h78;
      return so[k] + 8'(4 * op);
   endfunction : off

   // Status after a set, clear or direct write
   function automatic logic [31:0] nxt_sts(int k, int op, logic [31:0] c, logic [31:0] v);
      logic [31:0] r;
      r = op == 0 ? c | v : op == 1 ? c & ~v : k == 3 ? (c & ~sh[8]) | (v & sh[8]) : c;
      r = r & LM;
      if (k == 0) r = r | (~MM & LM);
      return r;
   endfunction : nxt_sts

   // Toggle a line, count cycles to the interrupt, then service it
   task automatic lat(int ln, output int n);
      @(posedge i_clk);
      ext[ln] <= ~ext[ln];
      n = 0;
      do begin
         @(posedge i_clk);
         #1 n++;
      end while (o_irq !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         finish_test();
      end
      repeat (6) @(posedge i_clk);
      rdc("pending", 8'h4c, 32'h1 << ln);
      chk("irq", 32'h0, {31'h0, o_irq});
   endtask : lat

   // Main sequence
   initial begin
      repeat (16) @(posedge i_clk);
      i_srst <= 0;
      chk("pullup_en", LM, o_pullup_en);
      for (k = 0; k < 9; k++) begin
         sh[k] = k == 0 ? (OWN_RST | ~MM) & LM : '0;
         rdc("reset", off(k, 2), sh[k]);
      end
      $display("reset test done");
      repeat (300) begin
         k = $unsigned($random(seed)) % 9;
         op = $unsigned($random(seed)) % 3;
         d = $random(seed);
         wr(off(k, op), d);
         sh[k] = nxt_sts(k, op, sh[k], d);
         rdc("status", off(k, 2), sh[k]);
         chk("pullup_en", ~sh[6] & LM, o_pullup_en);
      end
      $display("register test done");
      for (k = 0; k < 7; k++) wr(ca[k], '1);
      repeat (8) @(posedge i_clk);
      rdc("flush", 8'h48, 32'h0);
      // Drop the changes that the random phase left pending before the quiet check
      @(posedge i_clk);
      i_rd <= 1;
      i_addr <= 8'h4c;
      @(posedge i_clk);
      i_rd <= 0;
      wr(8'h4c, '1);
      rdc("pending", 8'h4c, ext);
      wr(8'h40, 32'h20);
      lat(5, n0);
      wr(8'h20, 32'h20);
      lat(5, n1);
      chk("filter_delay", 32'h1, 32'(n1 - n0));
      wr(8'h10, 32'h200);
      ext[12] <= 1;
      wr(8'h30, 32'h200);
      repeat (8) @(posedge i_clk);
      #1 chk("irq", 32'h0, {31'h0, o_irq});
      rdc("pending", 8'h4c, 32'h1200);
      rdc("pending", 8'h4c, 32'h0);
      rdc("pin_level", 8'h3c, (ext | 32'h200) & LM);
      $display("change test done");
      @(posedge i_clk);
      i_pclk_en <= 0;
      ext[5] <= 1;
      repeat (6) @(posedge i_clk);
      #1 chk("irq", 32'h0, {31'h0, o_irq});
      @(posedge i_clk);
      i_pclk_en <= 1;
      repeat (6) @(posedge i_clk);
      #1 chk("irq", 32'h1, {31'h0, o_irq});
      rdc("pending", 8'h4c, 32'h20);
      $display("clock test done");
      wr(8'h04, 32'h100);
      for (k = 0; k < 2; k++) begin
         wr(k ? 8'h70 : 8'h74, 32'h100);
         @(negedge i_clk);
         pd = k ? i_per_a : i_per_b;
         @(posedge i_clk);
         #1 chk("per_drive", {pd.level[8], pd.enable[8]}, {o_pin.level[8], o_pin.enable[8]});
      end
      wr(8'h10, 32'h400);
      wr(8'h50, 32'h400);
      @(posedge i_clk);
      #1 chk("open_drain", 32'h1, {o_pin.level[10], o_pin.enable[10]});
      wr(8'h30, 32'h400);
      @(posedge i_clk);
      #1 chk("open_drain", 32'h0, {o_pin.level[10], o_pin.enable[10]});
      $display("drive test done");
      foreach (so[k]) rdc("write_only", so[k], 32'h0);
      rdc("reserved", 8'h9c, 32'h0);
      $display("map test done");
      finish_test();
   end
endmodule : tb_io_line_controller

bind ilc_top ilc_top_asserts chk_i (.i_clk(i_clk), .i_srst(i_srst), .i_pclk_en(i_pclk_en),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_pin_in(i_pin_in), .o_pullup_en(o_pullup_en), .o_per_in(o_per_in), .o_irq(o_irq));

`default_nettype wire
